// File: hw/drive_warning_manager_map.svh
// register indices, field positions, warning indices and timing constants
`ifndef DRIVE_WARNING_MANAGER_MAP_SVH
`define DRIVE_WARNING_MANAGER_MAP_SVH
// --------------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------------
`define DWM_IDX_SEL_ONE 16'h3440
`define DWM_IDX_SEL_TWO 16'h3441
`define DWM_IDX_GEN_MASK 16'h3638
`define DWM_IDX_HOLD 16'h3759
`define DWM_IDX_LINK_CTRL 16'h3800
`define DWM_IDX_ERR_RESET 16'h4107
`define DWM_IDX_STATUS 16'h4100
`define DWM_RESET_VALUE 16'h0000
`define DWM_SEL_ALL 16'h0000
`define DWM_HOLD_COMM_BIT 0
`define DWM_HOLD_GEN_BIT 1
`define DWM_ERR_RESET_BIT 0
// --------------------------------------------------------------------
// warning indices inside the active vector
// --------------------------------------------------------------------
`define DWM_NUM_WARN 13
`define DWM_W_OVL 0
`define DWM_W_BATT 2
`define DWM_W_FAN 3
`define DWM_W_ENC_HOT 5
`define DWM_W_LIFE 7
`define DWM_W_DATA 10
// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define DWM_CLK_MHZ 100
`define DWM_HOLD_TIME_MS 1000
`define DWM_FAN_TIME_MS 1000
`define DWM_CYC_PER_MS (`DWM_CLK_MHZ * 1000)
`define DWM_TMR_W 27
`endif

// File: hw/drive_warning_pkg.sv
// types shared by the warning manager
package drive_warning_pkg;
    typedef enum logic [1:0] {
        KIND_SELECT = 2'h0,
        KIND_FIXED = 2'h1,
        KIND_AUTO = 2'h3,
        KIND_BATT = 2'h2
    } warn_kind_t;
    typedef struct packed {
        logic [3:0] sel_num;
        logic comm;
        logic [3:0] mask_bit;
        warn_kind_t kind;
    } warn_info_t;
    typedef struct packed {
        logic overload;
        logic regen;
        logic batt_held;
        logic fan_stopped;
        logic enc_comm;
        logic enc_hot;
        logic vibration;
        logic life_low;
        logic ext_enc;
        logic ext_enc_comm;
        logic data_setting;
        logic command;
        logic link_error;
    } mon_cond_t;
endpackage

// File: hw/drive_warning_manager.sv
// warning manager: detection masks, hold policy, alert line routing, wishbone slave
//
// Behaviour
// - with hold off, an active selectable warning clears itself one second after its cause goes.
// - with hold on, a selectable warning stays until cause is gone and error reset.
// - battery warning clears only after the encoder releases its held state.
// - line one selection zero routes all warnings, else the numbered one.
// - line two selection zero routes all warnings, else the numbered one.
// - general mask bit one disables detection of that general warning.
// - link control bit one disables detection of that link warning.
// - hold policy bit 0 covers link warnings, bit 1 general; 1 holds.
// - hold off still keeps a selectable warning one second after cause.
// - overload warning A0, selection 1, mask bit 7, hold selectable.
// - regeneration warning A1, selection 2, mask bit 5, hold selectable.
// - battery warning A2, selection 3, mask bit 0, always held.
// - fan warning A3 after one second of stopped fan; selection 4, bit 6.
// - encoder link warning A4, selection 5, mask bit 4, hold selectable.
// - encoder overheat warning A5, selection 6, mask bit 3, hold selectable.
// - encoder overheat is raised only with the 20-bit incremental encoder.
// - external encoder A8 sel 9 bit 8; vibration A6 sel 7 bit 9.
// - life expectancy warning A7, selection 8, mask bit 2, always held.
// - external encoder link warning A9, selection 10, mask bit 10, selectable.
// - held battery warning clears on error reset write without power cycle.
`timescale 1ns/1ns
`include "drive_warning_manager_map.svh"

module drive_warning_manager #(
    parameter int HOLD_CYC = `DWM_HOLD_TIME_MS * `DWM_CYC_PER_MS,
    parameter int FAN_CYC = `DWM_FAN_TIME_MS * `DWM_CYC_PER_MS
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic srst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // monitor conditions and encoder type
    input wire drive_warning_pkg::mon_cond_t mon_cond_i,
    input wire logic enc_inc20_i,
    // alert lines
    output logic alert_line_one_o,
    output logic alert_line_two_o
);

    // ----------------------------------------------------------------
    // warning table
    // ----------------------------------------------------------------
    function automatic drive_warning_pkg::warn_info_t warn_info(input int idx);
        warn_info = '{4'h0, 1'b0, 4'h0, drive_warning_pkg::KIND_AUTO};
        case (idx)
            0: warn_info = '{4'h1, 1'b0, 4'h7, drive_warning_pkg::KIND_SELECT};
            1: warn_info = '{4'h2, 1'b0, 4'h5, drive_warning_pkg::KIND_SELECT};
            2: warn_info = '{4'h3, 1'b0, 4'h0, drive_warning_pkg::KIND_BATT};
            3: warn_info = '{4'h4, 1'b0, 4'h6, drive_warning_pkg::KIND_AUTO};
            4: warn_info = '{4'h5, 1'b0, 4'h4, drive_warning_pkg::KIND_SELECT};
            5: warn_info = '{4'h6, 1'b0, 4'h3, drive_warning_pkg::KIND_SELECT};
            6: warn_info = '{4'h7, 1'b0, 4'h9, drive_warning_pkg::KIND_AUTO};
            7: warn_info = '{4'h8, 1'b0, 4'h2, drive_warning_pkg::KIND_FIXED};
            8: warn_info = '{4'h9, 1'b0, 4'h8, drive_warning_pkg::KIND_AUTO};
            9: warn_info = '{4'hA, 1'b0, 4'hA, drive_warning_pkg::KIND_SELECT};
            10: warn_info = '{4'hB, 1'b1, 4'h4, drive_warning_pkg::KIND_SELECT};
            11: warn_info = '{4'hC, 1'b1, 4'h5, drive_warning_pkg::KIND_AUTO};
            12: warn_info = '{4'hD, 1'b1, 4'h6, drive_warning_pkg::KIND_SELECT};
            default: warn_info = '{4'h0, 1'b0, 4'h0, drive_warning_pkg::KIND_AUTO};
        endcase
    endfunction

    // merge a 16-bit register with a write through the low two byte lanes
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0] sel);
        lane_merge = old;
        if (sel[0]) begin
            lane_merge[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            lane_merge[15:8] = dat[15:8];
        end
    endfunction

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdat_q;
    logic wr_en;
    logic [15:0] sel_one_q;
    logic [15:0] sel_two_q;
    logic [15:0] gen_mask_q;
    logic [15:0] hold_q;
    logic [15:0] link_ctrl_q;
    logic err_clr_q;
    logic [`DWM_NUM_WARN-1:0] raw_cond;
    logic [`DWM_NUM_WARN-1:0] det;
    logic [`DWM_NUM_WARN-1:0] active_q;
    logic [`DWM_NUM_WARN-1:0] match_one;
    logic [`DWM_NUM_WARN-1:0] match_two;
    logic [`DWM_TMR_W-1:0] tmr_q [`DWM_NUM_WARN];
    logic [`DWM_TMR_W-1:0] fan_cnt_q;
    logic fan_hit;
    logic line_one_q;
    logic line_two_q;

    // ----------------------------------------------------------------
    // wishbone slave: one wait state, ack for one cycle
    // ----------------------------------------------------------------
    assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
        end
    end

    // unmapped indices read as zero and ignore writes
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i) begin
            case (wb_adr_i)
                `DWM_IDX_SEL_ONE: rdat_q <= {16'h0000, sel_one_q};
                `DWM_IDX_SEL_TWO: rdat_q <= {16'h0000, sel_two_q};
                `DWM_IDX_GEN_MASK: rdat_q <= {16'h0000, gen_mask_q};
                `DWM_IDX_HOLD: rdat_q <= {16'h0000, hold_q};
                `DWM_IDX_LINK_CTRL: rdat_q <= {16'h0000, link_ctrl_q};
                `DWM_IDX_STATUS: rdat_q <= {19'h0_0000, active_q};
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sel_one_q <= `DWM_RESET_VALUE;
            sel_two_q <= `DWM_RESET_VALUE;
            gen_mask_q <= `DWM_RESET_VALUE;
            hold_q <= `DWM_RESET_VALUE;
            link_ctrl_q <= `DWM_RESET_VALUE;
        end else if (wr_en) begin
            case (wb_adr_i)
                `DWM_IDX_SEL_ONE: sel_one_q <= lane_merge(sel_one_q, wb_dat_i, wb_sel_i);
                `DWM_IDX_SEL_TWO: sel_two_q <= lane_merge(sel_two_q, wb_dat_i, wb_sel_i);
                `DWM_IDX_GEN_MASK: gen_mask_q <= lane_merge(gen_mask_q, wb_dat_i, wb_sel_i);
                `DWM_IDX_HOLD: hold_q <= lane_merge(hold_q, wb_dat_i, wb_sel_i);
                `DWM_IDX_LINK_CTRL: link_ctrl_q <= lane_merge(link_ctrl_q, wb_dat_i, wb_sel_i);
                default: ;
            endcase
        end
    end

    // error reset is a one-cycle pulse, nothing is stored
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            err_clr_q <= 1'b0;
        end else begin
            err_clr_q <= wr_en & (wb_adr_i == `DWM_IDX_ERR_RESET) & wb_sel_i[0]
                         & wb_dat_i[`DWM_ERR_RESET_BIT];
        end
    end

    // ----------------------------------------------------------------
    // conditions
    // ----------------------------------------------------------------
    // fan must stay stopped a full second; counter saturates
    always_ff @(posedge mclk_i) begin
        if (srst_i || !mon_cond_i.fan_stopped) begin
            fan_cnt_q <= '0;
        end else if (!fan_hit) begin
            fan_cnt_q <= fan_cnt_q + 1'b1;
        end
    end
    assign fan_hit = (fan_cnt_q == `DWM_TMR_W'(FAN_CYC));

    always_comb begin
        raw_cond = '0;
        raw_cond[0] = mon_cond_i.overload;
        raw_cond[1] = mon_cond_i.regen;
        raw_cond[2] = mon_cond_i.batt_held;
        raw_cond[3] = fan_hit;
        raw_cond[4] = mon_cond_i.enc_comm;
        raw_cond[5] = mon_cond_i.enc_hot & enc_inc20_i;
        raw_cond[6] = mon_cond_i.vibration;
        raw_cond[7] = mon_cond_i.life_low;
        raw_cond[8] = mon_cond_i.ext_enc;
        raw_cond[9] = mon_cond_i.ext_enc_comm;
        raw_cond[10] = mon_cond_i.data_setting;
        raw_cond[11] = mon_cond_i.command;
        raw_cond[12] = mon_cond_i.link_error;
    end

    // ----------------------------------------------------------------
    // per-warning state
    // ----------------------------------------------------------------
    for (genvar w = 0; w < `DWM_NUM_WARN; w++) begin : g_warn
        localparam drive_warning_pkg::warn_info_t INFO = warn_info(w);
        logic masked;
        logic hold_on;
        logic clear;

        assign masked = INFO.comm ? link_ctrl_q[INFO.mask_bit]
                                  : gen_mask_q[INFO.mask_bit];
        assign det[w] = raw_cond[w] & ~masked;
        assign hold_on = INFO.comm ? hold_q[`DWM_HOLD_COMM_BIT]
                                   : hold_q[`DWM_HOLD_GEN_BIT];

        // timer reloads while the cause is present, runs down after
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                tmr_q[w] <= '0;
            end else if (det[w]) begin
                tmr_q[w] <= `DWM_TMR_W'(HOLD_CYC);
            end else if (tmr_q[w] != '0) begin
                tmr_q[w] <= tmr_q[w] - 1'b1;
            end
        end

        always_comb begin
            case (INFO.kind)
                drive_warning_pkg::KIND_SELECT: begin
                    if (hold_on) begin
                        clear = err_clr_q;
                    end else begin
                        clear = (tmr_q[w] <= `DWM_TMR_W'(1)) | err_clr_q;
                    end
                end
                drive_warning_pkg::KIND_FIXED: clear = err_clr_q;
                drive_warning_pkg::KIND_BATT: clear = err_clr_q & ~mon_cond_i.batt_held;
                default: clear = 1'b1;
            endcase
        end

        // a fresh detection wins over any clear in the same cycle
        always_ff @(posedge mclk_i) begin
            if (srst_i) begin
                active_q[w] <= 1'b0;
            end else begin
                active_q[w] <= det[w] | (active_q[w] & ~clear);
            end
        end

        assign match_one[w] = (sel_one_q == `DWM_SEL_ALL) | (sel_one_q == {12'h000, INFO.sel_num});
        assign match_two[w] = (sel_two_q == `DWM_SEL_ALL) | (sel_two_q == {12'h000, INFO.sel_num});
    end

    // ----------------------------------------------------------------
    // alert lines and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            line_one_q <= 1'b0;
            line_two_q <= 1'b0;
        end else begin
            line_one_q <= |(active_q & match_one);
            line_two_q <= |(active_q & match_two);
        end
    end

    assign alert_line_one_o = line_one_q;
    assign alert_line_two_o = line_two_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_hold_off_clears;
        @(posedge mclk_i) disable iff (srst_i)
        (active_q[`DWM_W_OVL] && !det[`DWM_W_OVL] && !hold_q[`DWM_HOLD_GEN_BIT]
         && tmr_q[`DWM_W_OVL] == `DWM_TMR_W'(1)) |=> !active_q[`DWM_W_OVL];
    endproperty
    a_hold_off_clears: assert property (p_hold_off_clears)
        else $error("overload not auto-cleared after hold time");

    property p_hold_on_stays;
        @(posedge mclk_i) disable iff (srst_i)
        (active_q[`DWM_W_OVL] && hold_q[`DWM_HOLD_GEN_BIT] && !err_clr_q)
            |=> active_q[`DWM_W_OVL];
    endproperty
    a_hold_on_stays: assert property (p_hold_on_stays)
        else $error("held overload dropped without error reset");

    property p_batt_encoder;
        @(posedge mclk_i) disable iff (srst_i)
        (active_q[`DWM_W_BATT] && mon_cond_i.batt_held) |=> active_q[`DWM_W_BATT];
    endproperty
    a_batt_encoder: assert property (p_batt_encoder)
        else $error("battery cleared while encoder still holds it");

    property p_line_one_all;
        @(posedge mclk_i) disable iff (srst_i)
        (sel_one_q == `DWM_SEL_ALL && $changed(sel_one_q) == 1'b0 && |active_q)
            |=> alert_line_one_o;
    endproperty
    a_line_one_all: assert property (p_line_one_all)
        else $error("line one low with all selected and a warning active");

    property p_line_two_single;
        @(posedge mclk_i) disable iff (srst_i)
        (sel_two_q == 16'h0003 && active_q == (`DWM_NUM_WARN'(1) << `DWM_W_BATT))
            |=> alert_line_two_o;
    endproperty
    a_line_two_single: assert property (p_line_two_single)
        else $error("line two missed selected battery warning");

    property p_gen_mask;
        @(posedge mclk_i) disable iff (srst_i)
        (gen_mask_q[7] && !active_q[`DWM_W_OVL]) |=> !active_q[`DWM_W_OVL];
    endproperty
    a_gen_mask: assert property (p_gen_mask)
        else $error("masked overload became active");

    property p_link_mask;
        @(posedge mclk_i) disable iff (srst_i)
        (link_ctrl_q[4] && !active_q[`DWM_W_DATA]) |=> !active_q[`DWM_W_DATA];
    endproperty
    a_link_mask: assert property (p_link_mask)
        else $error("masked link warning became active");

    property p_enc_type;
        @(posedge mclk_i) disable iff (srst_i)
        (!enc_inc20_i && !active_q[`DWM_W_ENC_HOT]) |=> !active_q[`DWM_W_ENC_HOT];
    endproperty
    a_enc_type: assert property (p_enc_type)
        else $error("overheat raised with wrong encoder type");

    property p_fan_persist;
        @(posedge mclk_i) disable iff (srst_i)
        (!active_q[`DWM_W_FAN] && !fan_hit) |=> !active_q[`DWM_W_FAN];
    endproperty
    a_fan_persist: assert property (p_fan_persist)
        else $error("fan warning before one second of stop");

    property p_batt_reset;
        @(posedge mclk_i) disable iff (srst_i)
        (err_clr_q && !mon_cond_i.batt_held) |=> !active_q[`DWM_W_BATT];
    endproperty
    a_batt_reset: assert property (p_batt_reset)
        else $error("battery warning survived error reset");

    property p_hold_window;
        @(posedge mclk_i) disable iff (srst_i)
        (active_q[`DWM_W_OVL] && !det[`DWM_W_OVL] && !hold_q[`DWM_HOLD_GEN_BIT]
         && tmr_q[`DWM_W_OVL] > `DWM_TMR_W'(1) && !err_clr_q) |=> active_q[`DWM_W_OVL];
    endproperty
    a_hold_window: assert property (p_hold_window)
        else $error("overload dropped inside the hold window");

    property p_batt_held;
        @(posedge mclk_i) disable iff (srst_i)
        (active_q[`DWM_W_BATT] && !err_clr_q) |=> active_q[`DWM_W_BATT];
    endproperty
    a_batt_held: assert property (p_batt_held)
        else $error("battery warning dropped without error reset");

    property p_life_held;
        @(posedge mclk_i) disable iff (srst_i)
        (active_q[`DWM_W_LIFE] && !err_clr_q) |=> active_q[`DWM_W_LIFE];
    endproperty
    a_life_held: assert property (p_life_held)
        else $error("life warning dropped without error reset");

    property p_lines_idle;
        @(posedge mclk_i) disable iff (srst_i)
        (active_q == '0) |=> (!alert_line_one_o && !alert_line_two_o);
    endproperty
    a_lines_idle: assert property (p_lines_idle)
        else $error("alert line high with no active warning");

    property p_fan_restart;
        @(posedge mclk_i) disable iff (srst_i)
        !mon_cond_i.fan_stopped |=> !fan_hit;
    endproperty
    a_fan_restart: assert property (p_fan_restart)
        else $error("fan count not restarted after the fan ran");

endmodule

// File: bench/wb_host_model.sv
// host side model: classic wishbone master used to configure the warning manager
`timescale 1ns/1ns

module wb_host_model (
    // clock
    input wire logic mclk_i,
    // wishbone master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [17:2] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i,
    // set when an answer never came
    output logic timed_out_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 16'h0000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
        timed_out_o = 1'b0;
    end

    // one cycle; request held until the edge that sees ack, then released
    task automatic access(input logic we, input logic [15:0] idx, input logic [15:0] wval,
                          output logic [31:0] rval);
        int n;
        @(posedge mclk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= idx;
        wb_sel_o <= 4'h3;
        wb_dat_o <= {16'h0000, wval};
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (wb_ack_i !== 1'b1 && n < 50);
        if (n >= 50) timed_out_o = 1'b1;
        rval = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
    endtask
endmodule

// File: bench/drive_warning_manager_tb_top.sv
// self-checking bench for the warning manager
`timescale 1ns/1ns
`include "drive_warning_manager_map.svh"
`define CHK(name, exp, got) \
    begin samples_checked++; if ((got) !== (exp)) begin \
    $display("wrong value %s expected %h seen %h", name, exp, got); failures++; end end

module drive_warning_manager_tb_top;
    localparam int HOLD = 20;
    logic mclk_i;
    logic srst_i;
    logic cyc, stb, we, ack, tmo, line_one, line_two, inc20;
    logic [17:2] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, v;
    drive_warning_pkg::mon_cond_t cond;
    int failures = 0;
    int samples_checked = 0;
    // mask bit of general warning n
    int mbit[10] = '{7, 5, 0, 6, 4, 3, 9, 2, 8, 10};

    drive_warning_manager #(.HOLD_CYC(HOLD), .FAN_CYC(20)) u_dut (
        .mclk_i(mclk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mon_cond_i(cond), .enc_inc20_i(inc20),
        .alert_line_one_o(line_one), .alert_line_two_o(line_two));

    wb_host_model u_host (
        .mclk_i(mclk_i), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr),
        .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack),
        .timed_out_o(tmo));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic wr(input logic [15:0] idx, input logic [15:0] val);
        logic [31:0] d;
        u_host.access(1'b1, idx, val, d);
    endtask
    task automatic rd(input logic [15:0] idx, output logic [31:0] val);
        u_host.access(1'b0, idx, 16'h0000, val);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge mclk_i);
    endtask
    task automatic setc(input int n, input logic val);
        @(posedge mclk_i);
        cond[12-n] <= val;
    endtask
    task automatic clr_all();
        wr(`DWM_IDX_ERR_RESET, 16'h0001);
        wt(3);
    endtask
    task automatic report_and_stop();
        if (tmo) failures++;
        if (failures == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        #900000;
        failures++;
        report_and_stop();
    end

    // a lost answer ends the run at once
    always @(posedge mclk_i) begin
        if (tmo === 1'b1) begin
            report_and_stop();
        end
    end

    logic [15:0] regs[5] = '{`DWM_IDX_SEL_ONE, `DWM_IDX_SEL_TWO, `DWM_IDX_GEN_MASK,
                             `DWM_IDX_HOLD, `DWM_IDX_LINK_CTRL};

    initial begin
        srst_i = 1'b1;
        cond = '0;
        inc20 = 1'b0;
        wt(8);
        srst_i <= 1'b0;
        // ------------------------------------------------------------
        // reset values, unmapped place
        // ------------------------------------------------------------
        foreach (regs[i]) begin
            rd(regs[i], v);
            `CHK("reg reset", 32'h0000_0000, v)
        end
        wr(16'h1234, 16'hFFFF);
        rd(16'h1234, v);
        `CHK("unmapped", 32'h0000_0000, v)
        wr(`DWM_IDX_SEL_TWO, 16'h000A);
        rd(`DWM_IDX_SEL_TWO, v);
        `CHK("sel two", 32'h0000_000A, v)
        // ------------------------------------------------------------
        // overheat ignored without the incremental encoder
        // ------------------------------------------------------------
        setc(5, 1'b1);
        wt(5);
        rd(`DWM_IDX_STATUS, v);
        `CHK("overheat other enc", 1'b0, v[5])
        setc(5, 1'b0);
        inc20 <= 1'b1;
        // ------------------------------------------------------------
        // every general warning: mask, selection numbers, clear
        // ------------------------------------------------------------
        for (int n = 0; n < 10; n++) begin
            wr(`DWM_IDX_GEN_MASK, 16'h0001 << mbit[n]);
            wr(`DWM_IDX_SEL_ONE, 16'(n + 1));
            wr(`DWM_IDX_SEL_TWO, 16'((n + 1) % 10 + 1));
            setc(n, 1'b1);
            wt(25);
            rd(`DWM_IDX_STATUS, v);
            `CHK("masked", 1'b0, v[n])
            wr(`DWM_IDX_GEN_MASK, 16'h0000);
            wt(25);
            rd(`DWM_IDX_STATUS, v);
            `CHK("active", 1'b1, v[n])
            `CHK("line one", 1'b1, line_one)
            `CHK("line two", 1'b0, line_two)
            setc(n, 1'b0);
            clr_all();
            rd(`DWM_IDX_STATUS, v);
            `CHK("cleared", 32'h0000_0000, v)
        end
        // ------------------------------------------------------------
        // do-not-hold window, then hold policy per class
        // ------------------------------------------------------------
        wr(`DWM_IDX_SEL_ONE, 16'h0000);
        wr(`DWM_IDX_SEL_TWO, 16'h0000);
        setc(0, 1'b1);
        wt(3);
        setc(0, 1'b0);
        wt(HOLD + 1);
        `CHK("window one", 1'b1, line_one)
        `CHK("window two", 1'b1, line_two)
        wt(1);
        `CHK("auto clear", 1'b0, line_one)
        wr(`DWM_IDX_HOLD, 16'h0002);
        setc(0, 1'b1);
        setc(10, 1'b1);
        wt(3);
        setc(0, 1'b0);
        setc(10, 1'b0);
        wt(40);
        rd(`DWM_IDX_STATUS, v);
        `CHK("general held", 1'b1, v[0])
        `CHK("link not held", 1'b0, v[10])
        clr_all();
        `CHK("held cleared", 1'b0, line_one)
        // ------------------------------------------------------------
        // link mask
        // ------------------------------------------------------------
        for (int n = 10; n < 13; n++) begin
            wr(`DWM_IDX_LINK_CTRL, 16'h0001 << (n - 6));
            setc(n, 1'b1);
            wt(5);
            rd(`DWM_IDX_STATUS, v);
            `CHK("link masked", 1'b0, v[n])
            wr(`DWM_IDX_LINK_CTRL, 16'h0000);
            wt(3);
            rd(`DWM_IDX_STATUS, v);
            `CHK("link unmasked", 1'b1, v[n])
            setc(n, 1'b0);
            clr_all();
        end
        // ------------------------------------------------------------
        // battery held in the encoder; short fan stop
        // ------------------------------------------------------------
        wr(`DWM_IDX_HOLD, 16'h0000);
        wr(`DWM_IDX_SEL_TWO, 16'h0003);
        setc(2, 1'b1);
        wt(5);
        clr_all();
        rd(`DWM_IDX_STATUS, v);
        `CHK("batt encoder held", 1'b1, v[2])
        `CHK("line two batt", 1'b1, line_two)
        setc(2, 1'b0);
        wt(30);
        rd(`DWM_IDX_STATUS, v);
        `CHK("batt always held", 1'b1, v[2])
        clr_all();
        rd(`DWM_IDX_STATUS, v);
        `CHK("batt reset", 1'b0, v[2])
        setc(3, 1'b1);
        wt(15);
        setc(3, 1'b0);
        wt(5);
        rd(`DWM_IDX_STATUS, v);
        `CHK("short fan stop", 1'b0, v[3])
        report_and_stop();
    end
endmodule
